// file: rtl/mad_pkg.sv
// Constants, register map and control carrier of the multiply-add datapath.
package mad_pkg;
  localparam int OP_W = 16;
  localparam int C_W = 32;
  localparam int FULL_W = 34;
  localparam int STAGES = 3;
  localparam int MAX_LAT = 4;
  localparam logic [2:0] LAT_OPT = 3'h7;
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPA = 8'h04;
  localparam logic [7:0] REG_OPB = 8'h08;
  localparam logic [7:0] REG_OPC = 8'h0C;
  localparam logic [7:0] REG_PREC = 8'h10;
  localparam logic [7:0] REG_RES_LO = 8'h14;
  localparam logic [7:0] REG_RES_HI = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  // Control register field positions.
  localparam int CTRL_MADD = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_SIGNED = 3;
  localparam int CTRL_USER = 4;
  localparam int CTRL_FLOAT = 5;
  localparam int CTRL_ENPORT = 6;
  localparam int CTRL_LAT_LSB = 8;
  // Precision register field positions.
  localparam int PREC_NB_LSB = 0;
  localparam int PREC_BP_LSB = 8;
  localparam int PREC_ABP_LSB = 16;
  localparam int PREC_BBP_LSB = 20;
  localparam logic [31:0] CTRL_RST = 32'h0000_0008;
  localparam logic [31:0] PREC_RST = 32'h0000_0022;
  typedef enum logic [1:0] {
    MAD_OP_ADD = 2'h0,
    MAD_OP_SUB = 2'h1,
    MAD_OP_DYN = 2'h2
  } mad_op_t;
  typedef struct packed {
    logic [2:0] lat;
    logic en_port;
    logic is_float;
    logic user_prec;
    logic is_signed;
    mad_op_t op;
    logic madd;
  } mad_ctrl_t;
  typedef struct packed {
    logic [3:0] b_bp;
    logic [3:0] a_bp;
    logic [5:0] out_bp;
    logic [5:0] nbits;
  } mad_prec_t;
endpackage

// file: rtl/mad_stage.sv
// One enable-gated pipeline register of the multiply-add datapath.
`timescale 1ns/1ps
`default_nettype none
module mad_stage #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Data
  input wire logic hold_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] data_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_q <= '0;
    end else if (!hold_in) begin
      data_q <= d_in;
    end
  end
  assign q_out = data_q;
endmodule
`default_nettype wire

// file: rtl/mad_top.sv
// Multiply-add datapath with its classic Wishbone register slave.
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mad_top (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Datapath side controls
  input wire logic en_in,
  input wire logic sub_in,
  output logic [mad_pkg::FULL_W-1:0] result_out,
  output logic lat_err_out
);
  localparam int FW = mad_pkg::FULL_W;

  logic [31:0] ctrl_q;
  logic [31:0] prec_q;
  logic [mad_pkg::OP_W-1:0] opa_q;
  logic [mad_pkg::OP_W-1:0] opb_q;
  logic [mad_pkg::C_W-1:0] opc_q;
  logic [FW-1:0] result_q;
  logic lat_err_q;
  logic ack_q;
  logic [31:0] rdat_q;

  mad_pkg::mad_ctrl_t ctl;
  mad_pkg::mad_prec_t prc;
  // Reserved control and precision bits are skipped so the fields pack
  // tightly into their carriers.
  assign ctl = mad_pkg::mad_ctrl_t'({
    ctrl_q[mad_pkg::CTRL_LAT_LSB+2:mad_pkg::CTRL_LAT_LSB],
    ctrl_q[mad_pkg::CTRL_ENPORT:mad_pkg::CTRL_MADD]});
  assign prc = mad_pkg::mad_prec_t'({
    prec_q[mad_pkg::PREC_BBP_LSB+3:mad_pkg::PREC_ABP_LSB],
    prec_q[mad_pkg::PREC_BP_LSB+5:mad_pkg::PREC_BP_LSB],
    prec_q[mad_pkg::PREC_NB_LSB+5:mad_pkg::PREC_NB_LSB]});

  // Bus decode. Every access, mapped or not, is answered one cycle later.
  wire bus_req = wb_cyc_in && wb_stb_in && !ack_q;
  wire bus_wr = bus_req && wb_we_in;
  wire wr_ctrl = bus_wr && (wb_adr_in == mad_pkg::REG_CTRL);
  wire wr_opa = bus_wr && (wb_adr_in == mad_pkg::REG_OPA);
  wire wr_opb = bus_wr && (wb_adr_in == mad_pkg::REG_OPB);
  wire wr_opc = bus_wr && (wb_adr_in == mad_pkg::REG_OPC);
  wire wr_prec = bus_wr && (wb_adr_in == mad_pkg::REG_PREC);
  wire [31:0] be_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                         {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // Operand extension: a sign bit is only meaningful in signed mode.
  wire sg = ctl.is_signed;
  wire [mad_pkg::OP_W:0] a_ext = {sg & opa_q[mad_pkg::OP_W-1], opa_q};
  wire [mad_pkg::OP_W:0] b_ext = {sg & opb_q[mad_pkg::OP_W-1], opb_q};
  wire [FW-1:0] c_ext = {{(FW-mad_pkg::C_W){sg & opc_q[mad_pkg::C_W-1]}},
                         opc_q};
  // Product and combine stay at full width so nothing is lost.
  // Operands are widened before the product so its upper bits survive.
  wire [FW-1:0] prod = FW'($signed(a_ext)) * FW'($signed(b_ext));
  // Static add, static subtract, or the subtract input when dynamic.
  wire do_sub = (ctl.op == mad_pkg::MAD_OP_SUB) ||
                ((ctl.op == mad_pkg::MAD_OP_DYN) && sub_in);
  wire [FW-1:0] comb_sum = do_sub ? prod - c_ext : prod + c_ext;
  wire [FW-1:0] full_val = ctl.madd ? comb_sum : prod;

  // Latency legality. An illegal setting runs at the optimal latency and
  // raises the status flag, so software sees the mistake instead of a
  // silently wrong delay.
  wire lat_opt = (ctl.lat == mad_pkg::LAT_OPT);
  wire lat_zero = (ctl.lat == 3'h0);
  wire lat_pos = !lat_zero && !lat_opt &&
                 (ctl.lat <= 3'(mad_pkg::MAX_LAT));
  wire fix_ok = ctl.en_port ? lat_opt : (lat_zero || lat_opt);
  wire flt_ok = ctl.en_port ? lat_pos : (lat_zero || lat_pos);
  wire mul_ok = lat_zero || lat_pos || lat_opt;
  wire lat_ok = !ctl.madd ? mul_ok : (ctl.is_float ? flt_ok : fix_ok);
  wire [2:0] eff_lat = (lat_ok && !lat_opt) ? ctl.lat
                       : 3'(mad_pkg::MAX_LAT);

  // With the enable port configured, a low enable freezes the pipeline.
  wire hold = ctl.en_port && !en_in;

  // Three internal stages; tap k holds the value k samples old.
  logic [FW-1:0] taps [0:mad_pkg::STAGES];
  assign taps[0] = full_val;
  genvar gi;
  generate
    for (gi = 0; gi < mad_pkg::STAGES; gi = gi + 1) begin : g_pipe
      mad_stage #(
        .W(FW)
      ) u_stage (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .hold_in(hold),
        .d_in(taps[gi]),
        .q_out(taps[gi+1])
      );
    end
  endgenerate
  // The output register adds one sample, so latency L reads tap L-1 and latency 0 reads tap 0 like latency 1; only
  // latency 4 reaches through all three stages.
  wire [1:0] tap_idx = (eff_lat == 3'h0) ? 2'h0 : 2'(eff_lat - 3'h1);
  wire [FW-1:0] tap_val = taps[tap_idx];

  // Precision reduction. Floating operation ignores it entirely.
  wire reduce = ctl.user_prec && !ctl.is_float;
  wire [5:0] full_bp = 6'(prc.a_bp) + 6'(prc.b_bp);
  wire [5:0] drop = (full_bp > prc.out_bp) ? full_bp - prc.out_bp : 6'h0;
  wire [FW-1:0] shifted = sg ? FW'($signed(tap_val) >>> drop)
                             : tap_val >> drop;
  wire [5:0] nb = (prc.nbits == 6'h0 || prc.nbits > 6'(FW)) ? 6'(FW)
                  : prc.nbits;
  wire [FW-1:0] nb_mask = (FW'(1) << nb) - FW'(1);
  wire [FW-1:0] nb_sign = FW'(1) << (nb - 6'h1);
  // Wrap to the configured width, then sign-extend when signed.
  wire neg = sg && ((shifted & nb_sign) != '0);
  wire [FW-1:0] wrapped = (shifted & nb_mask) | (neg ? ~nb_mask : '0);
  wire [FW-1:0] out_val = reduce ? wrapped : tap_val;

  // Read mux.
  wire [31:0] status_w = {28'h0, eff_lat, lat_err_q};
  wire [31:0] res_hi_w = 32'(result_q[FW-1:32]);
  wire [31:0] rd_mux =
    (wb_adr_in == mad_pkg::REG_CTRL) ? ctrl_q :
    (wb_adr_in == mad_pkg::REG_OPA) ? 32'(opa_q) :
    (wb_adr_in == mad_pkg::REG_OPB) ? 32'(opb_q) :
    (wb_adr_in == mad_pkg::REG_OPC) ? opc_q :
    (wb_adr_in == mad_pkg::REG_PREC) ? prec_q :
    (wb_adr_in == mad_pkg::REG_RES_LO) ? result_q[31:0] :
    (wb_adr_in == mad_pkg::REG_RES_HI) ? res_hi_w :
    (wb_adr_in == mad_pkg::REG_STATUS) ? status_w : 32'h0000_0000;

  wire [31:0] ctrl_d = merge(ctrl_q, wb_dat_in, be_mask) & 32'h0000_077F;
  wire [31:0] prec_d = merge(prec_q, wb_dat_in, be_mask) & 32'h00FF_3F3F;
  wire [31:0] opa_d = merge(32'(opa_q), wb_dat_in, be_mask);
  wire [31:0] opb_d = merge(32'(opb_q), wb_dat_in, be_mask);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      rdat_q <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_q <= mad_pkg::CTRL_RST;
      prec_q <= mad_pkg::PREC_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= ctrl_d;
      if (wr_prec) prec_q <= prec_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      opa_q <= '0;
      opb_q <= '0;
      opc_q <= '0;
    end else begin
      if (wr_opa) opa_q <= opa_d[mad_pkg::OP_W-1:0];
      if (wr_opb) opb_q <= opb_d[mad_pkg::OP_W-1:0];
      if (wr_opc) opc_q <= merge(opc_q, wb_dat_in, be_mask);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      result_q <= '0;
      lat_err_q <= 1'b0;
    end else begin
      lat_err_q <= !lat_ok;
      if (!hold) result_q <= out_val;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;
  assign result_out = result_q;
  assign lat_err_out = lat_err_q;
endmodule
`default_nettype wire

// file: verif/mad_assertions.sv
// Port-level checks for the multiply-add datapath.
`timescale 1ns/1ps
`default_nettype none
module mad_assertions (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Wishbone
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Datapath
  input wire logic en_in,
  input wire logic sub_in,
  input wire logic [mad_pkg::FULL_W-1:0] result_out,
  input wire logic lat_err_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Cycles since anything that may move the result; the deepest pipe is 4.
  logic [3:0] quiet_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in || (wb_ack_out && wb_we_in) || $changed(en_in) || $changed(sub_in))
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;
  end
  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_ack;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  a_ack_follows_req: assert property (s_req |=> s_ack)
    else $error("ack did not pulse one cycle after a request");
  a_ack_has_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack rose without a request");
  a_ack_in_cycle: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in)
    else $error("ack outside a bus cycle");
  a_dat_idle_zero: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside ack");
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h1F |-> wb_dat_out == 32'h0)
    else $error("unmapped read returned data");
  a_reset_clears: assert property (disable iff (1'b0) rst_in |=> !wb_ack_out && result_out == '0 && !lat_err_out)
    else $error("outputs not cleared by reset");
  a_err_has_write: assert property ($changed(lat_err_out) |-> $past(wb_ack_out && wb_we_in) || $past(wb_ack_out && wb_we_in, 2))
    else $error("latency error flag moved without a write");
  a_result_settles: assert property (quiet_q > 4'h5 |-> $stable(result_out))
    else $error("result moved long after its last cause");
endmodule
`default_nettype wire

// file: verif/mad_partner.sv
// Surrounding logic model that drives the enable and subtract controls.
`timescale 1ns/1ps
`default_nettype none
module mad_partner (
  // Clock
  input wire logic core_clk_in,
  // Requests from the bench
  input wire logic en_req_in,
  input wire logic sub_req_in,
  // Controls into the datapath
  output logic en_out,
  output logic sub_out
);
  // Registered so that the controls only ever change just after an edge.
  always_ff @(posedge core_clk_in) begin
    en_out <= en_req_in;
    sub_out <= sub_req_in;
  end
endmodule
`default_nettype wire

// file: verif/mad_top_tb.sv
// Self-checking bench for the multiply-add datapath.
`timescale 1ns/1ps
`default_nettype none
module multiply_add_datapath_tb;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'hF;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out, en_in, sub_in, lat_err_out;
  logic en_req = 1'b1;
  logic sub_req = 1'b0;
  logic [33:0] result_out;
  int num_errors = 0;
  int check_count = 0;
  int cyc_cnt = 0;
  int land = 0;
  int chg = 0;
  logic [33:0] last_res = 34'h0;
  logic [31:0] ctl [6] = '{32'h209, 32'h49, 32'h749, 32'h229, 32'h69, 32'h408};
  logic bad [6] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) cyc_cnt <= cyc_cnt + 1;
  // Outputs are looked at mid-cycle, where they are settled.
  always @(negedge core_clk_in) begin
    if (result_out !== last_res) begin
      chg <= cyc_cnt;
      last_res <= result_out;
    end
  end
  mad_top dut (.core_clk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out,
    .en_in, .sub_in, .result_out, .lat_err_out);
  mad_partner partner (.core_clk_in, .en_req_in(en_req),
    .sub_req_in(sub_req), .en_out(en_in), .sub_out(sub_in));
  task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    land = cyc_cnt;
    q = wb_dat_out;
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [33:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    check(nm, e, {2'h0, q});
  endtask
  // Operand c keeps binary point 0, the sum of those of a and b.
  task automatic mac(input string nm, input logic [31:0] cw, a, b, c, input logic [33:0] e);
    wr(8'h00, cw);
    wr(8'h04, a);
    wr(8'h08, b);
    wr(8'h0C, c);
    repeat (3) @(posedge core_clk_in);
    check(nm, e, result_out);
  endtask
  task automatic lat(input string nm, input logic [31:0] cw, a, input logic [33:0] e, input int l);
    wr(8'h00, cw);
    repeat (8) @(posedge core_clk_in);
    wr(8'h04, a);
    repeat (8) @(posedge core_clk_in);
    check(nm, e, result_out);
    check(nm, 34'(l), 34'(chg - land));
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_in);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(posedge core_clk_in);
    rd("ctrl_rst", 8'h00, 34'h8);
    rd("prec_rst", 8'h10, 34'h22);
    rd("unmapped", 8'h40, 34'h0);
    mac("mul_s", 32'h8, 32'hFFFE, 32'h3, 32'h0, 34'h3FFFFFFFA);
    mac("mul_u", 32'h0, 32'hFFFE, 32'h3, 32'h0, 34'h2FFFA);
    wr(8'h10, 32'h8);
    mac("user", 32'h18, 32'hF, 32'hF, 32'h0, 34'h3FFFFFFE1);
    mac("float", 32'h38, 32'hF, 32'hF, 32'h0, 34'hE1);
    wr(8'h10, 32'h22);
    mac("madd", 32'h9, 32'h5, 32'h7, 32'h64, 34'h87);
    mac("msub", 32'hB, 32'h5, 32'h7, 32'h64, 34'h3FFFFFFBF);
    wr(8'h14, 32'h0);
    rd("res_lo", 8'h14, 34'hFFFFFFBF);
    rd("res_hi", 8'h18, 34'h3);
    sub_req <= 1'b1;
    mac("dyn_s", 32'hD, 32'h5, 32'h7, 32'h64, 34'h3FFFFFFBF);
    sub_req <= 1'b0;
    mac("dyn_a", 32'hD, 32'h5, 32'h7, 32'h64, 34'h87);
    lat("lat4", 32'h408, 32'h2, 34'hE, 4);
    lat("lat2", 32'h208, 32'h3, 34'h15, 2);
    lat("lat0", 32'h8, 32'h4, 34'h1C, 1);
    lat("lat_opt", 32'h708, 32'h5, 34'h23, 4);
    en_req <= 1'b0;
    wr(8'h00, 32'h448);
    wr(8'h04, 32'h6);
    repeat (8) @(posedge core_clk_in);
    check("held", 34'h23, result_out);
    en_req <= 1'b1;
    repeat (8) @(posedge core_clk_in);
    check("enabled", 34'h2A, result_out);
    for (int i = 0; i < 6; i++) begin
      wr(8'h00, ctl[i]);
      repeat (3) @(posedge core_clk_in);
      check("lat_err", {33'h0, bad[i]}, {33'h0, lat_err_out});
    end
    conclude();
  end
endmodule
bind mad_top mad_assertions u_chk (.core_clk_in, .rst_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .en_in,
  .sub_in, .result_out, .lat_err_out);
`default_nettype wire
